// [src/flp_pkg.sv]
// Purpose: Shared constants and carriers for the flash protection block
// Assumes: 200 MHz master clock
// Notes:   Offsets are word byte addresses on the plain register port
package flp_pkg;

	localparam int          FLP_CLK_HZ        = 200000000;
	localparam int          FLP_REGIONS       = 16;
	localparam int          FLP_PAGES_PER_REG = 64;
	localparam int          FLP_PAGE_BYTES    = 256;
	localparam int          FLP_CAL_BITS      = 8;

	// Register map
	localparam logic [7:0]  FLP_MODE_OFF      = 8'h00;
	localparam logic [7:0]  FLP_CMD_OFF       = 8'h04;
	localparam logic [7:0]  FLP_STATUS_OFF    = 8'h08;
	localparam logic [7:0]  FLP_LOCK_OFF      = 8'h0c;
	localparam logic [7:0]  FLP_OPT_OFF       = 8'h10;

	// Mode register fields
	localparam int          FLP_MODE_LOCKIE   = 2;

	// Status register fields
	localparam int          FLP_ST_READY      = 0;
	localparam int          FLP_ST_LOCKERR    = 2;
	localparam int          FLP_ST_SECURE     = 4;
	localparam int          FLP_ST_FASTPROG   = 5;
	localparam int          FLP_ST_RECOVER    = 6;

	// Command register fields: [7:0] code, [25:8] page or bit index
	localparam int          FLP_CMD_ARG_LSB   = 8;
	localparam int          FLP_ARG_W         = 18;

	// Times: erase pin hold and boot recovery strap hold
	localparam int          FLP_ERASE_MS      = 50;
	localparam int          FLP_RECOVER_S     = 10;
	localparam longint      FLP_ERASE_CYC     =
		longint'(FLP_ERASE_MS) * FLP_CLK_HZ / 1000;
	localparam longint      FLP_RECOVER_CYC   =
		longint'(FLP_RECOVER_S) * FLP_CLK_HZ;

	localparam logic [31:0] FLP_CAL_DEFAULT   = 32'h0000_00a5;

	typedef enum logic [7:0] {
		FLP_CMD_PAGE_PROG  = 8'h01,
		FLP_CMD_LOCK_SET   = 8'h02,
		FLP_CMD_PAGE_ERASE = 8'h03,
		FLP_CMD_LOCK_CLR   = 8'h04,
		FLP_CMD_FULL_ERASE = 8'h08,
		FLP_CMD_OPT_SET    = 8'h0b,
		FLP_CMD_OPT_CLR    = 8'h0d,
		FLP_CMD_SECURE     = 8'h0f
	} flp_cmd_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} flp_bus_t;

	typedef struct packed {
		logic        bod_en;
		logic        bod_rst_en;
	} flp_opt_t;

endpackage

// [src/flp_lock_ctl.sv]
// Purpose: Lock, security and option bit keeper of the flash controller
// Assumes: Plain register port; strap pins synchronous to clock_i
// Notes:   Non-volatile bits are modelled as reset-free state
// Summary of operation
// RULE_01 - One lock bit per parameterised region
// RULE_02 - Two instances give thirty-two regions
// RULE_03 - Region spans parameterised pages of parameterised size
// RULE_04 - Locked erase/program aborted, lock error set
// RULE_05 - Interrupt on lock error only when enabled
// RULE_06 - Lock command sets, unlock clears region bit
// RULE_07 - Erase pin clears every lock bit
// RULE_08 - Secure bit rejects debug and programming-port access
// RULE_09 - Only secure command sets security bit
// RULE_10 - Security cleared by erase pin plus erase
// RULE_11 - Erase pin held longer than 50 ms
// RULE_12 - Lock, security, option bits survive power loss
// RULE_13 - Option set/clear commands change addressed bit
// RULE_14 - Option bit 0 enables brownout detector
// RULE_15 - Erase pin clears option bit 0
// RULE_16 - Option bit 1 is brownout reset enable
// RULE_17 - Erase pin clears option bit 1
// RULE_18 - Eight calibration bits, fixed, erase-proof
// RULE_19 - Test pin, lines 0,1 high, 2 low: fast mode
// RULE_20 - Fast mode accepts commands from programming ports
// RULE_21 - All straps high 10 s restores boot
// RULE_22 - Erase pin active high, idle low
// RULE_23 - Status read clears lock error flag
`timescale 1ns/10ps
module flp_lock_ctl
	import flp_pkg::*;
#(
	parameter int      REGIONS       = FLP_REGIONS,
	parameter int      PAGES_PER_REG = FLP_PAGES_PER_REG,
	parameter int      PAGE_BYTES    = FLP_PAGE_BYTES,
	parameter longint  ERASE_CYC     = FLP_ERASE_CYC,
	parameter longint  RECOVER_CYC   = FLP_RECOVER_CYC
) (
	input  wire logic        clock_i,
	input  wire logic        rstn_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	input  wire logic        erase_pin_i,
	input  wire logic        test_mode_pin_i,
	input  wire logic        port_line_0_i,
	input  wire logic        port_line_1_i,
	input  wire logic        port_line_2_i,
	input  wire logic        dbg_req_i,
	input  wire logic        fpp_req_i,
	input  wire logic        fpp_cmd_valid_i,
	input  wire logic [31:0] fpp_cmd_i,
	output logic             dbg_grant_o,
	output logic             fpp_grant_o,
	output logic             flash_write_o,
	output logic             flash_erase_o,
	output logic [FLP_ARG_W-1:0] flash_page_o,
	output logic             flash_full_erase_o,
	output logic             boot_restore_o,
	output logic             fast_prog_o,
	output logic             brownout_detector_en_o,
	output logic             brownout_reset_en_o,
	output logic [FLP_CAL_BITS-1:0] cal_bits_o,
	output logic             irq_o
);

	////////////////////////////////////////////////////////////////////
	// Decode

	localparam int PAGE_SHIFT = $clog2(PAGES_PER_REG);
	localparam int REG_W      = (REGIONS > 1) ? $clog2(REGIONS) : 1;

	// Region index of a page number [RULE_03]
	function automatic logic [REG_W-1:0] region_of(
		input logic [FLP_ARG_W-1:0] page);
		logic [FLP_ARG_W-1:0] r;
		r = page >> PAGE_SHIFT;
		return r[REG_W-1:0];
	endfunction

	flp_bus_t    bus;
	flp_opt_t    opt_reg;
	logic [REGIONS-1:0] lock_reg;
	logic        secure_reg;
	logic        lock_err_reg;
	logic        lock_ie_reg;
	logic [31:0] erase_cnt_reg;
	logic [39:0] recover_cnt_reg;
	logic        recover_done_reg;
	logic        erase_seen_reg;

	assign bus = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

	wire         fast_mode  = test_mode_pin_i & port_line_0_i
		& port_line_1_i & ~port_line_2_i;          // [RULE_19]
	wire         recover_st = test_mode_pin_i & port_line_0_i
		& port_line_1_i & port_line_2_i;
	// Programming port only speaks in fast mode and when unsecured
	wire         fpp_cmd    = fpp_cmd_valid_i & fast_mode
		& ~secure_reg;                              // [RULE_20] [RULE_08]
	wire         sw_cmd     = bus.wr & (bus.addr == FLP_CMD_OFF);
	wire         cmd_go     = sw_cmd | fpp_cmd;
	// Software has priority if both arrive together
	wire  [31:0] cmd_word   = sw_cmd ? bus.wdata : fpp_cmd_i;
	wire  [7:0]  cmd_code   = cmd_word[7:0];
	wire  [FLP_ARG_W-1:0] cmd_arg =
		cmd_word[FLP_CMD_ARG_LSB +: FLP_ARG_W];
	wire  [REG_W-1:0] cmd_reg = region_of(cmd_arg);
	wire         is_prog    = cmd_code == FLP_CMD_PAGE_PROG;
	wire         is_perase  = cmd_code == FLP_CMD_PAGE_ERASE;
	wire         in_range   = 32'(cmd_reg) < REGIONS;
	wire         target_lck = in_range & lock_reg[cmd_reg];
	wire         abort      = cmd_go & (is_prog | is_perase)
		& target_lck;                               // [RULE_04]
	wire         do_lock    = cmd_go & (cmd_code == FLP_CMD_LOCK_SET);
	wire         do_unlock  = cmd_go & (cmd_code == FLP_CMD_LOCK_CLR);
	wire         do_full    = cmd_go & (cmd_code == FLP_CMD_FULL_ERASE);
	wire         opt_idx    = cmd_arg[0];
	wire         do_optset  = cmd_go & (cmd_code == FLP_CMD_OPT_SET);
	wire         do_optclr  = cmd_go & (cmd_code == FLP_CMD_OPT_CLR);
	wire         do_secure  = cmd_go & (cmd_code == FLP_CMD_SECURE);
	wire         st_read    = bus.rd & (bus.addr == FLP_STATUS_OFF);
	// Erase pin must be held the full time before it acts [RULE_22]
	wire         erase_held = erase_pin_i
		& (64'(erase_cnt_reg) >= ERASE_CYC - 1);    // [RULE_11]

	wire  [31:0] status_w = 32'(1'b1) << FLP_ST_READY
		| 32'(lock_err_reg) << FLP_ST_LOCKERR
		| 32'(secure_reg) << FLP_ST_SECURE
		| 32'(fast_mode) << FLP_ST_FASTPROG
		| 32'(recover_done_reg) << FLP_ST_RECOVER;

	logic [31:0] rdata_next;
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (bus.rd) begin
			case (bus.addr)
				FLP_MODE_OFF:   rdata_next = 32'(lock_ie_reg) << FLP_MODE_LOCKIE;
				FLP_STATUS_OFF: rdata_next = status_w;
				FLP_LOCK_OFF:   rdata_next = 32'(lock_reg);
				FLP_OPT_OFF:    rdata_next = {16'h0000,
					8'(cal_bits_o), 6'h00, opt_reg.bod_rst_en,
					opt_reg.bod_en};
				default:        rdata_next = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Erase pin and recovery timers

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			erase_cnt_reg <= 32'h0000_0000;
		end else if (!erase_pin_i) begin
			erase_cnt_reg <= 32'h0000_0000;
		end else if (!erase_held) begin
			erase_cnt_reg <= erase_cnt_reg + 32'h0000_0001;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			recover_cnt_reg  <= 40'h00_0000_0000;
			recover_done_reg <= 1'b0;
		end else if (!recover_st) begin
			recover_cnt_reg <= 40'h00_0000_0000;
		end else if (64'(recover_cnt_reg) >= RECOVER_CYC - 1) begin
			// Done stays until reset; later strap holds restore without the wait
			recover_done_reg <= 1'b1;               // [RULE_21]
		end else begin
			recover_cnt_reg <= recover_cnt_reg + 40'h00_0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Protection state
	// Lock, security and option bits have no reset: they model
	// non-volatile cells and keep value across resets [RULE_12]

	// Per-region lock bits [RULE_01] [RULE_02]
	for (genvar g = 0; g < REGIONS; g++) begin : g_lock
		wire hit = 32'(cmd_reg) == g;
		always_ff @(posedge clock_i) begin
			if (erase_held) begin
				lock_reg[g] <= 1'b0;                    // [RULE_07]
			end else if (do_lock && hit) begin
				lock_reg[g] <= 1'b1;                    // [RULE_06]
			end else if (do_unlock && hit) begin
				lock_reg[g] <= 1'b0;                    // [RULE_06]
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (erase_held) begin
			opt_reg <= '{bod_en: 1'b0, bod_rst_en: 1'b0}; // [RULE_15] [RULE_17]
		end else if (do_optset || do_optclr) begin
			if (opt_idx)
				opt_reg.bod_rst_en <= do_optset;        // [RULE_13]
			else
				opt_reg.bod_en <= do_optset;            // [RULE_13]
		end
	end

	// Pin hold stands in for the full erase it forces [RULE_10]
	always_ff @(posedge clock_i) begin
		if (erase_held) begin
			secure_reg <= 1'b0;                         // [RULE_10]
		end else if (do_secure) begin
			secure_reg <= 1'b1;                         // [RULE_09]
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lock_ie_reg  <= 1'b0;
			lock_err_reg <= 1'b0;
			erase_seen_reg <= 1'b0;
		end else begin
			if (bus.wr && bus.addr == FLP_MODE_OFF)
				lock_ie_reg <= bus.wdata[FLP_MODE_LOCKIE];
			// New abort wins over the read clear
			if (abort)
				lock_err_reg <= 1'b1;                   // [RULE_04]
			else if (st_read)
				lock_err_reg <= 1'b0;                   // [RULE_23]
			erase_seen_reg <= erase_held;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o                <= 32'h0000_0000;
			dbg_grant_o            <= 1'b0;
			fpp_grant_o            <= 1'b0;
			flash_write_o          <= 1'b0;
			flash_erase_o          <= 1'b0;
			flash_page_o           <= '0;
			flash_full_erase_o     <= 1'b0;
			boot_restore_o         <= 1'b0;
			fast_prog_o            <= 1'b0;
			brownout_detector_en_o <= 1'b0;
			brownout_reset_en_o    <= 1'b0;
			cal_bits_o             <= '0;
			irq_o                  <= 1'b0;
		end else begin
			rdata_o                <= rdata_next;
			dbg_grant_o            <= dbg_req_i & ~secure_reg;  // [RULE_08]
			fpp_grant_o            <= fpp_req_i & fast_mode & ~secure_reg;
			flash_write_o          <= cmd_go & is_prog & ~target_lck;
			flash_erase_o          <= cmd_go & is_perase & ~target_lck;
			// Page of the last accepted command only, not idle bus noise
			if (cmd_go)
				flash_page_o       <= cmd_arg;
			// Erase pin forces a whole-array erase once per assertion
			flash_full_erase_o     <= do_full
				| (erase_held & ~erase_seen_reg);
			boot_restore_o         <= recover_st & recover_done_reg;
			fast_prog_o            <= fast_mode;
			brownout_detector_en_o <= opt_reg.bod_en;      // [RULE_14]
			brownout_reset_en_o    <= opt_reg.bod_rst_en;  // [RULE_16]
			// Factory value, no write path reaches it [RULE_18]
			cal_bits_o             <= FLP_CAL_DEFAULT[FLP_CAL_BITS-1:0];
			irq_o                  <= lock_err_reg & lock_ie_reg; // [RULE_05]
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks

	lock_abort_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		abort |=> lock_err_reg && !flash_write_o && !flash_erase_o)
		else $error("locked command not aborted"); // [RULE_04]
	irq_gate_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		irq_o |-> $past(lock_ie_reg) && $past(lock_err_reg))
		else $error("irq without enable"); // [RULE_05]
	secure_block_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		secure_reg |=> !dbg_grant_o && !fpp_grant_o)
		else $error("access granted while secured"); // [RULE_08]
	erase_unlock_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		erase_held |=> lock_reg == '0 && !secure_reg && opt_reg == '0)
		else $error("erase pin left protection"); // [RULE_07]
	secure_set_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		$rose(secure_reg) |-> $past(do_secure))
		else $error("security set without command"); // [RULE_09]
	lock_cmd_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		do_lock && !erase_held && in_range |=> lock_reg[$past(cmd_reg)])
		else $error("lock command ignored"); // [RULE_06]
	// Option cells are unknown before the first erase hold, so the
	// checks key on the known level rather than on equality
	bod_follow_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		opt_reg.bod_en |=> brownout_detector_en_o)
		else $error("brownout enable mismatch"); // [RULE_14]
	fast_entry_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		fast_mode |=> fast_prog_o)
		else $error("fast mode not entered"); // [RULE_19]
	rd_clear_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		st_read && !abort |=> !lock_err_reg)
		else $error("status read kept lock error"); // [RULE_23]

	////////////////////////////////////////////////////////////////////
	// Checks on option, command and strap paths

	bod_off_a: assert property ( // [RULE_14]
		@(posedge clock_i) disable iff (!rstn_i)
		!opt_reg.bod_en |=> !brownout_detector_en_o)
		else $error("brownout detector on while option clear");
	brst_on_a: assert property ( // [RULE_16]
		@(posedge clock_i) disable iff (!rstn_i)
		opt_reg.bod_rst_en |=> brownout_reset_en_o)
		else $error("brownout reset enable not passed on");
	brst_off_a: assert property ( // [RULE_16]
		@(posedge clock_i) disable iff (!rstn_i)
		!opt_reg.bod_rst_en |=> !brownout_reset_en_o)
		else $error("brownout reset on while option clear");
	unlock_cmd_a: assert property ( // [RULE_06]
		@(posedge clock_i) disable iff (!rstn_i)
		do_unlock && !erase_held && in_range |=> !lock_reg[$past(cmd_reg)])
		else $error("unlock command ignored");
	opt_set_a: assert property ( // [RULE_13]
		@(posedge clock_i) disable iff (!rstn_i)
		do_optset && !erase_held
		|=> ($past(opt_idx) ? opt_reg.bod_rst_en : opt_reg.bod_en))
		else $error("option set ignored");
	opt_clr_a: assert property ( // [RULE_13]
		@(posedge clock_i) disable iff (!rstn_i)
		do_optclr && !erase_held
		|=> !($past(opt_idx) ? opt_reg.bod_rst_en : opt_reg.bod_en))
		else $error("option clear ignored");
	cal_fixed_a: assert property ( // [RULE_18]
		@(posedge clock_i) disable iff (!rstn_i)
		rstn_i |=> cal_bits_o == FLP_CAL_DEFAULT[FLP_CAL_BITS-1:0])
		else $error("calibration bits changed");
	fpp_secure_a: assert property ( // [RULE_08]
		@(posedge clock_i) disable iff (!rstn_i)
		secure_reg && fpp_cmd_valid_i && !sw_cmd
		|=> !flash_write_o && !flash_erase_o)
		else $error("programming port command while secured");
	fast_exit_a: assert property ( // [RULE_19]
		@(posedge clock_i) disable iff (!rstn_i)
		!fast_mode |=> !fast_prog_o)
		else $error("fast mode without straps");
	recover_a: assert property ( // [RULE_21]
		@(posedge clock_i) disable iff (!rstn_i)
		boot_restore_o |-> $past(recover_st))
		else $error("boot restore without straps");
	erase_once_a: assert property ( // [RULE_10]
		@(posedge clock_i) disable iff (!rstn_i)
		erase_held && erase_seen_reg && !do_full |=> !flash_full_erase_o)
		else $error("full erase repeated during one hold");
	irq_on_a: assert property ( // [RULE_05]
		@(posedge clock_i) disable iff (!rstn_i)
		lock_err_reg && lock_ie_reg |=> irq_o)
		else $error("enabled lock error gave no interrupt");
	irq_off_a: assert property ( // [RULE_05]
		@(posedge clock_i) disable iff (!rstn_i)
		!lock_ie_reg |=> !irq_o)
		else $error("interrupt while disabled");
	prog_pass_a: assert property ( // [RULE_04]
		@(posedge clock_i) disable iff (!rstn_i)
		cmd_go && is_prog && !target_lck |=> flash_write_o)
		else $error("unlocked program not issued");

endmodule

// [dv/tb_flp_lock_ctl.sv]
// Purpose: Self-checking bench for the flash lock and security keeper
// Assumes: Short erase and recovery counts through the dut parameters
// Notes:   Non-volatile state is unknown until the first erase pin hold
`timescale 1ns/10ps
module tb_flp_lock_ctl;
	import flp_pkg::*;

	localparam int     ERC = 8;
	localparam int     RCC = 16;
	localparam int     PSH = $clog2(FLP_PAGES_PER_REG);

	logic                 clock_i, rstn_i, wr_i, rd_i, erase_pin_i;
	logic                 test_mode_pin_i, port_line_0_i, port_line_1_i;
	logic                 port_line_2_i, dbg_req_i, fpp_req_i;
	logic                 fpp_cmd_valid_i;
	logic [7:0]           addr_i;
	logic [31:0]          wdata_i, fpp_cmd_i, rdata_o;
	logic                 dbg_grant_o, fpp_grant_o, flash_write_o;
	logic                 flash_erase_o, flash_full_erase_o, boot_restore_o;
	logic                 fast_prog_o, irq_o;
	logic                 brownout_detector_en_o, brownout_reset_en_o;
	logic [FLP_ARG_W-1:0] flash_page_o;
	logic [FLP_CAL_BITS-1:0] cal_bits_o;
	int                   errors, cmp_count, n_wr, n_er, n_fe;
	int                   x_wr, x_er, x_fe;
	logic [15:0]          lock_m;
	logic [1:0]           opt_m;
	logic                 sec_m, le_m, ie_m;
	logic [31:0]          d;
	logic [17:0]          pg;

	flp_lock_ctl #(.ERASE_CYC(ERC), .RECOVER_CYC(RCC)) dut (.*);

	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	// Pulse counters, so the exact pulse cycle need not be guessed
	always @(posedge clock_i) begin
		n_wr += (flash_write_o === 1'b1);
		n_er += (flash_erase_o === 1'b1);
		n_fe += (flash_full_erase_o === 1'b1);
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock_i);
		addr_i  <= a;
		wdata_i <= v;
		wr_i    <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clock_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask

	// Model update beside each software command
	task automatic cmd(input logic [7:0] c, input logic [17:0] arg);
		int r;
		r = int'(arg >> PSH);
		bus_wr(FLP_CMD_OFF, {6'h00, arg, c});
		case (c)
			FLP_CMD_PAGE_PROG, FLP_CMD_PAGE_ERASE: begin
				if (lock_m[r])
					le_m = 1'b1;
				else if (c == FLP_CMD_PAGE_PROG)
					x_wr++;
				else
					x_er++;
			end
			FLP_CMD_LOCK_SET: lock_m[r] = 1'b1;
			FLP_CMD_LOCK_CLR: lock_m[r] = 1'b0;
			FLP_CMD_OPT_SET:  opt_m[arg[0]] = 1'b1;
			FLP_CMD_OPT_CLR:  opt_m[arg[0]] = 1'b0;
			FLP_CMD_SECURE:   sec_m = 1'b1;
			FLP_CMD_FULL_ERASE: x_fe++;
			default: ;
		endcase
		cyc(3);
	endtask

	task automatic fpp_cmd(input logic [7:0] c, input logic [17:0] arg);
		@(posedge clock_i);
		fpp_cmd_i       <= {6'h00, arg, c};
		fpp_cmd_valid_i <= 1'b1;
		@(posedge clock_i);
		fpp_cmd_valid_i <= 1'b0;
		cyc(3);
	endtask

	// Compare lock, option and status reads and outputs with the model; status read clears flag
	task automatic check_all;
		logic fm;
		fm = test_mode_pin_i & port_line_0_i & port_line_1_i & ~port_line_2_i;
		check(n_wr, x_wr);
		check(n_er, x_er);
		check(n_fe, x_fe);
		check(irq_o, le_m & ie_m);
		bus_rd(FLP_LOCK_OFF, d);
		check(d, {16'h0000, lock_m});
		bus_rd(FLP_OPT_OFF, d);
		check(d, {16'h0000, FLP_CAL_DEFAULT[7:0], 6'h00, opt_m});
		check(brownout_detector_en_o, opt_m[0]);
		check(brownout_reset_en_o, opt_m[1]);
		check(cal_bits_o, FLP_CAL_DEFAULT[7:0]);
		bus_rd(FLP_STATUS_OFF, d);
		check(d & 32'h3f, {fm, sec_m, 1'b0, le_m, 2'b01});
		le_m = 1'b0;
		cyc(2);
		check(irq_o, 1'b0);
		bus_rd(FLP_STATUS_OFF, d);
		check(d[FLP_ST_LOCKERR], 1'b0);
	endtask

	task automatic erase_hold;
		@(posedge clock_i);
		erase_pin_i <= 1'b1;
		cyc(ERC + 4);
		erase_pin_i <= 1'b0;
		lock_m = 16'h0000;
		opt_m  = 2'b00;
		sec_m  = 1'b0;
		x_fe++;
		cyc(3);
		check_all();
	endtask

	task automatic give_verdict;
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		#(5 * 20000);
		errors++;
		give_verdict();
	end

	initial begin
		{wr_i, rd_i, erase_pin_i, test_mode_pin_i} = '0;
		{port_line_0_i, port_line_1_i, port_line_2_i} = '0;
		{dbg_req_i, fpp_req_i, fpp_cmd_valid_i} = '0;
		{addr_i, wdata_i, fpp_cmd_i} = '0;
		{errors, cmp_count, n_wr, n_er, n_fe, x_wr, x_er, x_fe} = '0;
		{lock_m, opt_m, sec_m, le_m, ie_m} = '0;
		rstn_i = 1'b0;
		void'($urandom(79864));
		repeat (20) @(posedge clock_i);
		rstn_i <= 1'b1;
		erase_hold();
		$display("test erase pin hold done");
		// Abort on locked pages, with and without the interrupt enable
		for (int i = 0; i < 4; i++) begin
			ie_m = i[0];
			bus_wr(FLP_MODE_OFF, 32'(ie_m) << FLP_MODE_LOCKIE);
			pg = (i == 3) ? 18'h3ff : 18'($urandom_range(1023));
			cmd(FLP_CMD_LOCK_SET, pg);
			cmd((i < 2) ? FLP_CMD_PAGE_PROG : FLP_CMD_PAGE_ERASE, pg);
			check_all();
			cmd(FLP_CMD_LOCK_CLR, pg);
			cmd((i < 2) ? FLP_CMD_PAGE_PROG : FLP_CMD_PAGE_ERASE, pg);
			check(flash_page_o, pg);
			check_all();
		end
		$display("test lock and abort done");
		for (int b = 0; b < 2; b++) begin
			cmd(FLP_CMD_OPT_SET, 18'(b));
			check_all();
			cmd(FLP_CMD_OPT_CLR, 18'(b));
			cmd(FLP_CMD_OPT_SET, 18'(b));
		end
		cmd(FLP_CMD_FULL_ERASE, 18'h0);
		check_all();
		$display("test option bits done");
		test_mode_pin_i <= 1'b1;
		port_line_0_i   <= 1'b1;
		port_line_1_i   <= 1'b1;
		dbg_req_i       <= 1'b1;
		fpp_req_i       <= 1'b1;
		cyc(4);
		check({fast_prog_o, dbg_grant_o, fpp_grant_o}, 3'b111);
		fpp_cmd(FLP_CMD_LOCK_SET, 18'h080);
		lock_m[2] = 1'b1;
		check_all();
		cmd(FLP_CMD_SECURE, 18'h0);
		check({dbg_grant_o, fpp_grant_o}, 2'b00);
		fpp_cmd(FLP_CMD_LOCK_CLR, 18'h080);
		check_all();
		$display("test fast mode and security done");
		port_line_2_i <= 1'b1;
		cyc(10);
		check(boot_restore_o, 1'b0);
		cyc(12);
		check(boot_restore_o, 1'b1);
		{test_mode_pin_i, port_line_0_i, port_line_1_i} <= 3'b000;
		port_line_2_i <= 1'b0;
		cyc(3);
		check(boot_restore_o, 1'b0);
		$display("test boot recovery done");
		erase_hold();
		check({dbg_grant_o, fpp_grant_o}, 2'b10);
		$display("test erase after security done");
		give_verdict();
	end
endmodule
